/* core/acr_spi_restart_ctrl.sv */
`include "acr_params.svh"

module acr_spi_restart_ctrl import acr_pkg::*; #(
  parameter logic [1:0] DEV_ADDR = 2'b01,
  parameter int SETUP_CYCLES = `ACR_SETUP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic data_ready,
  input wire logic scan_between_cycles,
  input wire logic crc_flag_clr,
  output logic sdo,
  output logic sdo_oe,
  output logic analog_clock_output,
  output logic conv_reset,
  output logic conv_restart,
  output logic start_pulse,
  output logic settling,
  output logic scan_restart,
  output logic [7:0] main_config_register,
  output logic [7:0] scan_config,
  output logic [7:0] timer_config,
  output logic [15:0] cfg_crc,
  output logic crc_flag,
  output logic locked
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pins_s;
  logic cs_s;
  logic sck_s;
  logic sdi_s;

  // link pins cross into the master clock domain
  acr_sync #(
    .W(3),
    .RST_VAL(3'b100)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .din({cs_n, sck, sdi}),
    .dout(pins_s)
  );

  assign cs_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // state

  localparam acr_state_t RST_STATE = acr_state_reset();

  acr_state_t q;
  acr_state_t d;

  logic sck_rise;
  logic sck_fall;
  logic unlocked;
  logic scan_mode;
  logic [7:0] rx_byte;
  logic [7:0] status_byte;
  logic [7:0] rd_crc_byte;
  logic [15:0] rd_crc_out;
  logic [15:0] bg_crc_out;

  // sck edges only count while selected
  assign sck_rise = sck_s & ~q.sck_d & ~cs_s & ~q.cs_d;
  assign sck_fall = ~sck_s & q.sck_d & ~cs_s & ~q.cs_d;
  assign unlocked = (q.regs[`ACR_ADDR_LOCK] == `ACR_LOCK_KEY);
  assign scan_mode = q.regs[`ACR_ADDR_SCAN][`ACR_SCAN_EN];
  assign rx_byte = {q.rx, sdi_s};
  assign status_byte = {2'b00, DEV_ADDR, ~DEV_ADDR[0], ~data_ready, ~q.crc_flag, 1'b1};
  assign rd_crc_byte = sck_fall ? q.tx_hold : rx_byte;

  ////////////////////////////////////////////////////////////////////////////
  // checksum engines

  acr_crc16 u_rd_crc (
    .crc_in(q.rd_crc),
    .data_in(rd_crc_byte),
    .crc_out(rd_crc_out)
  );

  acr_crc16 u_bg_crc (
    .crc_in(q.bg_crc),
    .data_in(q.regs[q.bg_idx]),
    .crc_out(bg_crc_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic req_imm;
    logic req_dly;
    logic req_scan;
    logic wr_ok;
    logic rd_load;
    logic rd_static;
    logic restart_done;
    logic crc_set;
    logic [3:0] rd_addr;
    logic [7:0] rd_val;
    req_imm = 1'b0;
    req_dly = 1'b0;
    req_scan = 1'b0;
    wr_ok = 1'b0;
    rd_load = 1'b0;
    rd_static = 1'b0;
    restart_done = 1'b0;
    crc_set = 1'b0;
    rd_addr = q.addr;
    rd_val = 8'h00;
    d = q;
    d.sck_d = sck_s;
    d.cs_d = cs_s;
    d.conv_reset = 1'b0;
    d.conv_restart = 1'b0;
    d.start_pulse = 1'b0;
    d.scan_restart = 1'b0;

    // serial link
    if (cs_s) begin
      d.spi = SPI_IDLE;
      d.sdo_oe = 1'b0;
      d.load_next = 1'b0;
    end else if (q.cs_d) begin
      d.spi = SPI_CMD;
      d.sdo_oe = 1'b1;
      d.tx = status_byte;
      d.bit_cnt = 3'h0;
      d.rose = 1'b0;
      d.load_next = 1'b0;
      d.crc_phase = 2'h0;
      d.rd_crc = `ACR_CRC_INIT;
    end else begin
      if (sck_rise) begin
        d.rx = rx_byte[6:0];
        d.bit_cnt = q.bit_cnt + 3'h1;
        d.rose = 1'b1;
        if (q.bit_cnt == 3'h7) begin
          unique case (q.spi)
            SPI_CMD: begin
              if (rx_byte[7:6] != DEV_ADDR) begin
                d.spi = SPI_IGN;
                d.sdo_oe = 1'b0;
              end else begin
                d.rd_crc = rd_crc_out;
                unique case (rx_byte[1:0])
                  `ACR_TYPE_FAST: begin
                    d.spi = SPI_IGN;
                    d.sdo_oe = 1'b0;
                    if (q.regs[`ACR_ADDR_CTRL][`ACR_CTRL_FAST]) begin
                      case (rx_byte[5:2])
                        `ACR_FC_START: begin
                          d.regs[`ACR_ADDR_MAIN][`ACR_MODE_MSB:`ACR_MODE_LSB] = `ACR_MODE_CONV;
                          req_imm = 1'b1;
                        end
                        `ACR_FC_STANDBY: begin
                          d.regs[`ACR_ADDR_MAIN][`ACR_MODE_MSB:`ACR_MODE_LSB] = `ACR_MODE_STANDBY;
                        end
                        `ACR_FC_ADC_SD: begin
                          d.regs[`ACR_ADDR_MAIN][`ACR_MODE_MSB:`ACR_MODE_LSB] = `ACR_MODE_ADC_SD;
                        end
                        `ACR_FC_FULL_SD: begin
                          d.regs[`ACR_ADDR_MAIN] = 8'h00;
                        end
                        `ACR_FC_FULL_RST: begin
                          d.regs = acr_reg_defaults();
                        end
                        default: begin
                        end
                      endcase
                    end
                  end
                  `ACR_TYPE_WRITE: begin
                    d.spi = SPI_WR;
                    d.sdo_oe = 1'b0;
                    d.addr = rx_byte[5:2];
                  end
                  `ACR_TYPE_SRD, `ACR_TYPE_IRD: begin
                    d.spi = SPI_RD;
                    d.static_rd = (rx_byte[1:0] == `ACR_TYPE_SRD);
                    rd_load = 1'b1;
                    rd_addr = rx_byte[5:2];
                    rd_static = (rx_byte[1:0] == `ACR_TYPE_SRD);
                  end
                endcase
              end
            end
            SPI_WR: begin
              // lock register itself stays writable so software can unlock
              wr_ok = (unlocked || q.addr == `ACR_ADDR_LOCK) &&
                      q.addr != `ACR_ADDR_CRC_HI && q.addr != `ACR_ADDR_CRC_LO;
              d.addr = q.addr + 4'h1;
              if (wr_ok) begin
                d.regs[q.addr] = rx_byte;
                if (q.addr == `ACR_ADDR_MAIN) begin
                  if (rx_byte != q.regs[`ACR_ADDR_MAIN]) begin
                    req_dly = 1'b1;
                  end else begin
                    req_imm = 1'b1;
                  end
                end
                if (q.addr == `ACR_ADDR_RSV_B || q.addr == `ACR_ADDR_RSV_C) begin
                  req_dly = 1'b1;
                end
                if (q.addr == `ACR_ADDR_SCAN) begin
                  if (!scan_mode) begin
                    req_scan = rx_byte[`ACR_SCAN_EN];
                  end else begin
                    req_scan = ~scan_between_cycles;
                  end
                end
                if (q.addr == `ACR_ADDR_TIMER) begin
                  req_scan = scan_mode & scan_between_cycles;
                end
              end
            end
            SPI_RD: begin
              if (q.regs[`ACR_ADDR_CTRL][`ACR_CTRL_RDCRC] && q.frame_end &&
                  q.crc_phase == 2'h0) begin
                d.tx_hold = q.rd_crc[15:8];
                d.hold_is_data = 1'b0;
                d.load_next = 1'b1;
                d.crc_phase = 2'h1;
              end else if (q.crc_phase == 2'h1) begin
                d.tx_hold = q.rd_crc[7:0];
                d.hold_is_data = 1'b0;
                d.load_next = 1'b1;
                d.crc_phase = 2'h2;
              end else begin
                if (q.crc_phase == 2'h2) begin
                  d.rd_crc = `ACR_CRC_INIT;
                end
                d.crc_phase = 2'h0;
                rd_load = 1'b1;
                rd_addr = q.addr;
                rd_static = q.static_rd;
              end
            end
            SPI_IDLE, SPI_IGN: begin
            end
          endcase
        end
      end
      if (sck_fall && q.rose) begin
        if (q.load_next) begin
          d.tx = q.tx_hold;
          d.load_next = 1'b0;
          if (q.hold_is_data) begin
            d.rd_crc = rd_crc_out;
          end
        end else begin
          d.tx = {q.tx[6:0], 1'b0};
        end
      end
    end

    // read data fetch
    if (rd_addr == `ACR_ADDR_CRC_HI) begin
      rd_val = q.crc_reg[15:8];
    end else if (rd_addr == `ACR_ADDR_CRC_LO) begin
      rd_val = q.crc_reg[7:0];
    end else begin
      rd_val = q.regs[rd_addr];
    end
    if (rd_load) begin
      d.tx_hold = rd_val;
      d.hold_is_data = 1'b1;
      d.load_next = 1'b1;
      d.frame_end = rd_static || rd_addr == `ACR_ADDR_LAST;
      d.addr = rd_static ? rd_addr : rd_addr + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion reset and restart sequencer, plus the scan restart pulse
    if (req_imm || req_dly) begin
      d.conv_reset = 1'b1;
      d.analog_clock_output_cnt = '0;
      d.rst = RST_WAIT;
      d.settle_pend = req_dly;
      d.rst_cnt = (|q.analog_clock_output_cnt) ? `ACR_WAIT_LONG - 16'h1 : `ACR_WAIT_SHORT - 16'h1;
    end else begin
      d.analog_clock_output_cnt = q.analog_clock_output_cnt + `ACR_ANALOG_CLOCK_OUTPUT_W'(1);
      unique case (q.rst)
        RST_IDLE: begin
        end
        RST_WAIT: begin
          if (q.rst_cnt == 16'h0) begin
            if (q.settle_pend) begin
              d.rst = RST_SETTLE;
              d.rst_cnt = 16'(SETUP_CYCLES - 1);
            end else begin
              restart_done = 1'b1;
            end
          end else begin
            d.rst_cnt = q.rst_cnt - 16'h1;
          end
        end
        RST_SETTLE: begin
          if (q.rst_cnt == 16'h0) begin
            restart_done = 1'b1;
          end else begin
            d.rst_cnt = q.rst_cnt - 16'h1;
          end
        end
      endcase
    end
    if (restart_done) begin
      d.rst = RST_IDLE;
      d.conv_restart = 1'b1;
      d.start_pulse = q.regs[`ACR_ADDR_CTRL][`ACR_CTRL_STP];
    end
    d.scan_restart = req_scan;

    ////////////////////////////////////////////////////////////////////////
    // background configuration checksum
    if (!unlocked) begin
      if (q.bg_idx == `ACR_BG_LAST) begin
        d.crc_reg = bg_crc_out;
        d.bg_crc = `ACR_CRC_INIT;
        d.bg_idx = 4'h0;
        d.crc_valid = 1'b1;
        crc_set = q.crc_valid && bg_crc_out != q.crc_reg;
      end else begin
        d.bg_crc = bg_crc_out;
        d.bg_idx = q.bg_idx + 4'h1;
      end
    end else begin
      d.bg_crc = `ACR_CRC_INIT;
      d.bg_idx = 4'h0;
      d.crc_valid = 1'b0;
    end
    // set wins over clear
    d.crc_flag = crc_set | (q.crc_flag & ~crc_flag_clr);
  end

  // power-on reset holds the serial logic idle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sdo = q.tx[7];
  assign sdo_oe = q.sdo_oe;
  assign analog_clock_output = q.analog_clock_output_cnt[`ACR_ANALOG_CLOCK_OUTPUT_W-1];
  assign conv_reset = q.conv_reset;
  assign conv_restart = q.conv_restart;
  assign start_pulse = q.start_pulse;
  assign settling = (q.rst == RST_SETTLE);
  assign scan_restart = q.scan_restart;
  assign main_config_register = q.regs[`ACR_ADDR_MAIN];
  assign scan_config = q.regs[`ACR_ADDR_SCAN];
  assign timer_config = q.regs[`ACR_ADDR_TIMER];
  assign cfg_crc = q.crc_reg;
  assign crc_flag = q.crc_flag;
  assign locked = ~unlocked;

endmodule

/* core/acr_params.svh */
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// register offsets
`define ACR_ADDR_MAIN 4'h1
`define ACR_ADDR_CTRL 4'h5
`define ACR_ADDR_SCAN 4'h7
`define ACR_ADDR_TIMER 4'h8
`define ACR_ADDR_RSV_B 4'hb
`define ACR_ADDR_RSV_C 4'hc
`define ACR_ADDR_LOCK 4'hd
`define ACR_ADDR_CRC_HI 4'he
`define ACR_ADDR_CRC_LO 4'hf
`define ACR_ADDR_LAST 4'hf
`define ACR_BG_LAST 4'hd

// field positions and values
`define ACR_LOCK_KEY 8'ha5
`define ACR_CTRL_RST 8'h02
`define ACR_CTRL_STP 0
`define ACR_CTRL_FAST 1
`define ACR_CTRL_RDCRC 2
`define ACR_SCAN_EN 0
`define ACR_MODE_MSB 1
`define ACR_MODE_LSB 0
`define ACR_MODE_CONV 2'h3
`define ACR_MODE_STANDBY 2'h2
`define ACR_MODE_ADC_SD 2'h0

// command byte
`define ACR_TYPE_FAST 2'h0
`define ACR_TYPE_SRD 2'h1
`define ACR_TYPE_WRITE 2'h2
`define ACR_TYPE_IRD 2'h3
`define ACR_FC_START 4'ha
`define ACR_FC_STANDBY 4'hb
`define ACR_FC_ADC_SD 4'hc
`define ACR_FC_FULL_SD 4'hd
`define ACR_FC_FULL_RST 4'he

// timing counts in master clock periods, except ACR_SETUP_DMCLK, which counts periods of the divided clock
`define ACR_WAIT_SHORT 16'h0002
`define ACR_WAIT_LONG 16'h0004
`define ACR_SETUP_DMCLK 256
`define ACR_DMCLK_DIV 4
`define ACR_SETUP_CYCLES (`ACR_SETUP_DMCLK * `ACR_DMCLK_DIV)
`define ACR_ANALOG_CLOCK_OUTPUT_W 2

// checksum
`define ACR_CRC_POLY 16'h8005
`define ACR_CRC_INIT 16'h0000

`endif

/* core/acr_pkg.sv */
`include "acr_params.svh"

package acr_pkg;

  typedef enum logic [4:0] {
    SPI_IDLE = 5'b00001,
    SPI_CMD  = 5'b00010,
    SPI_WR   = 5'b00100,
    SPI_RD   = 5'b01000,
    SPI_IGN  = 5'b10000
  } acr_spi_state_t;

  typedef enum logic [2:0] {
    RST_IDLE   = 3'b001,
    RST_WAIT   = 3'b010,
    RST_SETTLE = 3'b100
  } acr_rst_state_t;

  typedef logic [15:0][7:0] acr_regmap_t;

  typedef struct packed {
    acr_regmap_t regs;
    acr_spi_state_t spi;
    logic sck_d;
    logic cs_d;
    logic rose;
    logic load_next;
    logic hold_is_data;
    logic frame_end;
    logic static_rd;
    logic sdo_oe;
    logic [2:0] bit_cnt;
    logic [6:0] rx;
    logic [7:0] tx;
    logic [7:0] tx_hold;
    logic [3:0] addr;
    logic [1:0] crc_phase;
    logic [15:0] rd_crc;
    acr_rst_state_t rst;
    logic [15:0] rst_cnt;
    logic settle_pend;
    logic [`ACR_ANALOG_CLOCK_OUTPUT_W-1:0] analog_clock_output_cnt;
    logic conv_reset;
    logic conv_restart;
    logic start_pulse;
    logic scan_restart;
    logic [3:0] bg_idx;
    logic [15:0] bg_crc;
    logic [15:0] crc_reg;
    logic crc_valid;
    logic crc_flag;
  } acr_state_t;

  function automatic acr_regmap_t acr_reg_defaults();
    acr_regmap_t r;
    r = '0;
    r[`ACR_ADDR_LOCK] = `ACR_LOCK_KEY;
    r[`ACR_ADDR_CTRL] = `ACR_CTRL_RST;
    return r;
  endfunction

  function automatic acr_state_t acr_state_reset();
    acr_state_t s;
    s = '0;
    s.regs = acr_reg_defaults();
    s.spi = SPI_IDLE;
    s.rst = RST_IDLE;
    s.cs_d = 1'b1;
    s.rd_crc = `ACR_CRC_INIT;
    s.bg_crc = `ACR_CRC_INIT;
    return s;
  endfunction

endpackage

/* core/acr_sync.sv */
module acr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acr_sync_st_t;

  acr_sync_st_t q;
  acr_sync_st_t d;

  // first stage feeds only the second stage
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule

/* core/acr_crc16.sv */
`include "acr_params.svh"

module acr_crc16 #(
  parameter logic [15:0] POLY = `ACR_CRC_POLY
) (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [15:0] crc_out
);

  // one byte of crc-16, msb first
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data_in[i]) begin
        c = {c[14:0], 1'b0} ^ POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule

/* tb/acr_host.sv */
module acr_host (
  output logic cs_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode1;
  logic line;
  // released data line reads as pulled up
  assign line = sdo_oe ? sdo : 1'b1;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    mode1 = 1'b0;
  end
  task automatic open_frame(input logic m1);
    mode1 = m1;
    sck = m1; // idle level changed only while deselected
    #100;
    cs_n = 1'b0;
    #64;
  endtask
  // command byte first, then data, msb first
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      sdi = tx[i];
      #32;
      rx[i] = line;
      sck = 1'b1; // data sampled on the rising edge
      #32;
    end
    sck = mode1;
  endtask
  task automatic close_frame();
    #32;
    cs_n = 1'b1;
    sdi = ~sdi;
    #100;
  endtask
endmodule

/* tb/acr_spi_restart_ctrl_asserts.sv */
module acr_spi_restart_ctrl_asserts #(
  parameter int SETUP_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic crc_flag_clr,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic conv_reset,
  input wire logic conv_restart,
  input wire logic start_pulse,
  input wire logic analog_clock_output,
  input wire logic settling,
  input wire logic crc_flag,
  input wire logic locked
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] gap_reg;
  logic [15:0] len_reg;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gap_reg <= 16'hffff;
      len_reg <= 16'h0000;
    end else begin
      if (conv_reset)
        gap_reg <= 16'h0001;
      else if (gap_reg != 16'hffff)
        gap_reg <= gap_reg + 16'h0001;
      len_reg <= settling ? len_reg + 16'h0001 : 16'h0000;
    end
  end
  //////////////////////////////////////////////////////////////////////
  oe_idle_a: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  status_msb_a: assert property ($fell(cs_n) |-> ##5 (sdo_oe && !sdo))
    else $error("status msb missing after select");
  restart_gap_a: assert property (conv_restart |-> gap_reg inside
    {[16'h0002:16'h0004], [SETUP_CYCLES + 2:SETUP_CYCLES + 4]})
    else $error("restart at wrong distance from reset");
  analog_clock_output_phase_a: assert property (conv_reset |->
    !analog_clock_output ##1 !analog_clock_output ##1 analog_clock_output)
    else $error("analog clock phase not restarted");
  reset_pulse_a: assert property (conv_reset |=> !conv_reset)
    else $error("conversion reset longer than one cycle");
  pulse_gate_a: assert property (start_pulse |-> conv_restart)
    else $error("start pulse without restart");
  settle_len_a: assert property ($fell(settling) |-> len_reg == SETUP_CYCLES)
    else $error("settling length wrong");
  settle_end_a: assert property ($fell(settling) |-> ##[0:2] conv_restart)
    else $error("no restart after settling");
  flag_sticky_a: assert property (crc_flag && !crc_flag_clr |=> crc_flag)
    else $error("checksum flag dropped");
  flag_locked_a: assert property ($rose(crc_flag) |-> $past(locked))
    else $error("checksum flag set while unlocked");
endmodule

bind acr_spi_restart_ctrl acr_spi_restart_ctrl_asserts #(.SETUP_CYCLES(SETUP_CYCLES))
  acr_spi_restart_ctrl_asserts_i (.sys_clk, .rstn, .cs_n, .crc_flag_clr, .sdo, .sdo_oe,
  .conv_reset, .conv_restart, .start_pulse, .analog_clock_output, .settling, .crc_flag,
  .locked);

/* tb/test_adc_spi_config_restart_ctrl.sv */
`include "acr_params.svh"

module test_adc_spi_config_restart_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 8;
  logic sys_clk = 1'b0;
  logic rstn;
  logic cs_n;
  logic sck;
  logic sdi;
  logic data_ready;
  logic scan_between_cycles;
  logic crc_flag_clr;
  logic sdo;
  logic sdo_oe;
  logic conv_reset;
  logic conv_restart;
  logic start_pulse;
  logic settling;
  logic scan_restart;
  logic [7:0] main_config_register;
  logic [7:0] scan_config;
  logic [7:0] timer_config;
  logic [15:0] cfg_crc;
  logic crc_flag;
  logic locked;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int rst_at = 0;
  int gap = 0;
  int n_rst = 0;
  int n_stp = 0;
  int n_scan = 0;
  //////////////////////////////////////////////////////////////////////
  acr_spi_restart_ctrl #(.DEV_ADDR(2'b01), .SETUP_CYCLES(S)) acr_spi_restart_ctrl_i (
    .sys_clk, .rstn, .cs_n, .sck, .sdi, .data_ready, .scan_between_cycles, .crc_flag_clr,
    .sdo, .sdo_oe, .analog_clock_output(), .conv_reset, .conv_restart, .start_pulse,
    .settling, .scan_restart, .main_config_register, .scan_config, .timer_config,
    .cfg_crc, .crc_flag, .locked);
  acr_host acr_host_i (.cs_n, .sck, .sdi, .sdo, .sdo_oe);
  always #4 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (conv_reset === 1'b1) begin
      rst_at = cyc;
      n_rst++;
    end
    if (conv_restart === 1'b1)
      gap = cyc - rst_at;
    if (start_pulse === 1'b1)
      n_stp++;
    if (scan_restart === 1'b1)
      n_scan++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_in(input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      errors++;
      $display("[ERR] t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
    end
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `ACR_CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic frame(input logic [7:0] c, input logic [7:0] d, input int n);
    logic [7:0] r;
    acr_host_i.open_frame(1'b0);
    acr_host_i.xfer(c, 8, r);
    if (n > 0)
      acr_host_i.xfer(d, n, r);
    acr_host_i.close_frame();
    idle(40);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    frame({2'b01, a, `ACR_TYPE_WRITE}, d, 8);
  endtask
  task automatic rd(input logic [7:0] c, input logic m1, output logic [7:0] st,
    output logic [7:0] d);
    acr_host_i.open_frame(m1);
    acr_host_i.xfer(c, 8, st);
    acr_host_i.xfer(8'h00, 8, d);
    acr_host_i.close_frame();
    idle(4);
  endtask
  task automatic pulse_clr();
    crc_flag_clr = 1'b1;
    idle(1);
    crc_flag_clr = 1'b0;
    idle(30);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_read();
    logic [7:0] st;
    logic [7:0] d;
    wr(`ACR_ADDR_MAIN, 8'h5b);
    for (int m = 0; m < 2; m++) begin
      data_ready = m[0];
      rd({2'b01, `ACR_ADDR_MAIN, m ? `ACR_TYPE_SRD : `ACR_TYPE_IRD}, m[0], st, d);
      chk({4'h1, 1'b0, ~m[0], 2'h3}, st);
      chk(8'h5b, d);
    end
    data_ready = 1'b0;
  endtask
  task automatic t_rdcrc();
    logic [7:0] c;
    logic [7:0] st;
    logic [7:0] d;
    logic [7:0] h;
    logic [7:0] l;
    c = {2'b01, `ACR_ADDR_MAIN, `ACR_TYPE_SRD};
    wr(`ACR_ADDR_CTRL, 8'h04);
    acr_host_i.open_frame(1'b1);
    acr_host_i.xfer(c, 8, st);
    acr_host_i.xfer(8'h00, 8, d);
    acr_host_i.xfer(8'h00, 8, h);
    acr_host_i.xfer(8'h00, 8, l);
    acr_host_i.close_frame();
    chk(8'h5b, d);
    chk(crc_step(crc_step(`ACR_CRC_INIT, c), 8'h5b), {h, l});
  endtask
  task automatic rst_row(input logic [3:0] a, input logic [7:0] d, input logic slow);
    int r0;
    int p0;
    r0 = n_rst;
    p0 = n_stp;
    wr(a, d);
    chk(r0 + 1, n_rst);
    chk(p0 + 1, n_stp);
    if (slow)
      chk_in(S + 2, S + 4, gap);
    else
      chk_in(2, 4, gap);
  endtask
  task automatic scan_row(input logic b, input logic [3:0] a, input logic [7:0] d,
    input logic e);
    int s0;
    s0 = n_scan;
    scan_between_cycles = b;
    wr(a, d);
    chk(s0 + e, n_scan);
    if (a == `ACR_ADDR_TIMER)
      chk(d, timer_config);
    else if (a == `ACR_ADDR_SCAN)
      chk(d, scan_config);
  endtask
  task automatic fast_row(input logic [7:0] p, input logic [3:0] fc, input logic [7:0] e);
    wr(`ACR_ADDR_MAIN, p);
    frame({2'b01, fc, `ACR_TYPE_FAST}, 8'h00, 0);
    chk(e, main_config_register);
  endtask
  task automatic t_lock();
    logic [7:0] st;
    logic [7:0] hi;
    logic [15:0] e;
    logic [13:0][7:0] v;
    // register image expected while locked, index 0xd down to 0x0
    v = {8'h11, 8'h22, 8'h11, 16'h0000, 8'h30, 16'h0000, 8'h03, 24'h000000, 8'h5b, 8'h00};
    e = `ACR_CRC_INIT;
    for (int i = 0; i < 14; i++)
      e = crc_step(e, v[i]);
    wr(`ACR_ADDR_LOCK, 8'h00);
    pulse_clr();
    chk(2'b10, {locked, crc_flag});
    wr(`ACR_ADDR_MAIN, 8'h77);
    chk(8'h5b, main_config_register);
    wr(`ACR_ADDR_LOCK, 8'h11);
    chk(1'b1, crc_flag);
    rd({2'b01, `ACR_ADDR_CRC_HI, `ACR_TYPE_SRD}, 1'b0, st, hi);
    chk(e[15:8], hi);
    chk(e, cfg_crc);
    pulse_clr();
    wr(`ACR_ADDR_LOCK, `ACR_LOCK_KEY);
    chk(1'b0, locked);
  endtask
  task automatic t_misc();
    logic [7:0] st;
    logic [7:0] d;
    frame({2'b01, `ACR_ADDR_MAIN, `ACR_TYPE_WRITE}, 8'ha0, 4);
    chk(8'h5b, main_config_register);
    rd({2'b11, `ACR_ADDR_MAIN, `ACR_TYPE_IRD}, 1'b0, st, d);
    chk(8'hff, d);
    frame({2'b10, `ACR_ADDR_MAIN, `ACR_TYPE_WRITE}, 8'h99, 8);
    chk(8'h5b, main_config_register);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    data_ready = 1'b0;
    scan_between_cycles = 1'b0;
    crc_flag_clr = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    idle(2);
    chk(11'h000, {main_config_register, sdo_oe, locked, crc_flag});
    t_read();
    t_rdcrc();
    wr(`ACR_ADDR_CTRL, 8'h03);
    rst_row(`ACR_ADDR_MAIN, 8'h5a, 1'b1);
    rst_row(`ACR_ADDR_MAIN, 8'h5a, 1'b0);
    rst_row(`ACR_ADDR_RSV_B, 8'h11, 1'b1);
    rst_row(`ACR_ADDR_RSV_C, 8'h22, 1'b1);
    scan_row(1'b0, `ACR_ADDR_TIMER, 8'h10, 1'b0);
    scan_row(1'b0, `ACR_ADDR_SCAN, 8'h01, 1'b1);
    scan_row(1'b0, `ACR_ADDR_SCAN, 8'h01, 1'b1);
    scan_row(1'b0, `ACR_ADDR_TIMER, 8'h20, 1'b0);
    scan_row(1'b1, `ACR_ADDR_SCAN, 8'h01, 1'b0);
    scan_row(1'b1, `ACR_ADDR_TIMER, 8'h30, 1'b1);
    scan_row(1'b0, `ACR_ADDR_MAIN, 8'h5b, 1'b0);
    scan_row(1'b0, `ACR_ADDR_SCAN, 8'h00, 1'b1);
    scan_row(1'b0, `ACR_ADDR_SCAN, 8'h00, 1'b0);
    t_misc();
    t_lock();
    fast_row(8'h57, `ACR_FC_STANDBY, 8'h56);
    fast_row(8'h57, `ACR_FC_ADC_SD, 8'h54);
    fast_row(8'h54, `ACR_FC_START, 8'h57);
    fast_row(8'h57, `ACR_FC_FULL_SD, 8'h00);
    fast_row(8'h57, 4'hf, 8'h57);
    fast_row(8'h33, `ACR_FC_FULL_RST, 8'h00);
    complete_run();
  end
endmodule
